// *** common/mcsm_defs.vh ***
// Functional notes
// - Clear bit holds single-error counters at zero
// - Eight-bit threshold, reset zero, must be exceeded
// - Per-channel flag sets when errors exceed threshold
// - Reading a threshold flag clears it
// - Read-only bit shows PHY initialization finished
// - Sticky bit records catastrophic temperature report
// - Address is region code above 17-bit offset
// - Monitor counters present, registers 32 bits wide
// - Two monitor modes: repeating and single interval
// - Repeating mode copies results, restarts interval automatically
// - Writing repeat bit selects and starts repeating
// - Single enable runs exactly one interval
// - 32-bit interval length in memory clocks
// - Done bit sets when tracking registers update
// - Done bit clears itself after being read
// - Count writes and auto-precharge writes per channel
// - Count reads and auto-precharge reads per channel
// - Count refresh commands per channel per interval
// - Count activate commands per channel per interval
// - Count single-bank precharges per channel per interval
// - Error counters saturate at 255 until cleared
// - Upper five bits select the controller region
// - One APB port, private 22-bit address space
`ifndef MCSM_DEFS_VH
`define MCSM_DEFS_VH

// ----------------------------------------------------------------
// Address layout
// ----------------------------------------------------------------
`define MCSM_ADDR_W          22
`define MCSM_OFFS_W          17
`define MCSM_REGION_W        5
`define MCSM_REGION_DEFAULT  5'h08

// ----------------------------------------------------------------
// Register offsets within the region
// ----------------------------------------------------------------
`define MCSM_OFS_ERR_CLEAR   17'h05818
`define MCSM_OFS_ERR_THRESH  17'h0585c
`define MCSM_OFS_FLAG_CH0    17'h05864
`define MCSM_OFS_FLAG_CH1    17'h05868
`define MCSM_OFS_PHY_DONE    17'h10034
`define MCSM_OFS_OVERTEMP    17'h1004c
`define MCSM_OFS_MON_REPEAT  17'h13800
`define MCSM_OFS_MON_SINGLE  17'h13804
`define MCSM_OFS_MON_LENGTH  17'h13808
`define MCSM_OFS_MON_DONE    17'h1380c
`define MCSM_OFS_WR_CH0      17'h13814
`define MCSM_OFS_WR_CH1      17'h13818
`define MCSM_OFS_WRAP_CH0    17'h13820
`define MCSM_OFS_WRAP_CH1    17'h13824
`define MCSM_OFS_RD_CH0      17'h1382c
`define MCSM_OFS_RD_CH1      17'h13830
`define MCSM_OFS_RDAP_CH0    17'h13838
`define MCSM_OFS_RDAP_CH1    17'h1383c
`define MCSM_OFS_REF_CH0     17'h13844
`define MCSM_OFS_REF_CH1     17'h13848
`define MCSM_OFS_ACT_CH0     17'h13850
`define MCSM_OFS_ACT_CH1     17'h13854
`define MCSM_OFS_PRE_CH0     17'h1385c
`define MCSM_OFS_PRE_CH1     17'h13860

// ----------------------------------------------------------------
// Widths, reset values and limits
// ----------------------------------------------------------------
`define MCSM_DATA_W          32
`define MCSM_ERR_W           8
`define MCSM_ERR_MAX         8'hff
`define MCSM_THRESH_RESET    8'h00
`define MCSM_LENGTH_RESET    32'h00000000

// ----------------------------------------------------------------
// Memory command codes seen by the monitor
// ----------------------------------------------------------------
`define MCSM_CMD_WR          3'h0
`define MCSM_CMD_WRAP        3'h1
`define MCSM_CMD_RD          3'h2
`define MCSM_CMD_RDAP        3'h3
`define MCSM_CMD_REF         3'h4
`define MCSM_CMD_ACT         3'h5
`define MCSM_CMD_PRE         3'h6
`define MCSM_CMD_KINDS       7
`define MCSM_TRACK_NUM       14
`define MCSM_TRACK_NONE      4'hf

`endif

// *** core/mcsm_status_monitor.v ***
`timescale 1ns/1ps
`default_nettype none
`include "mcsm_defs.vh"

module mcsm_status_monitor
#(
  parameter [4:0] REGION_CODE = `MCSM_REGION_DEFAULT
)
(
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // APB requester side
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [21:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // ECC error events, same clock, one pulse per error
  input  wire        ecc_error_chan0,
  input  wire        ecc_error_chan1,
  // Memory command stream, same clock
  input  wire        cmd_valid_chan0,
  input  wire [2:0]  cmd_code_chan0,
  input  wire        cmd_valid_chan1,
  input  wire [2:0]  cmd_code_chan1,
  // Levels from the PHY, asynchronous to core_clk
  input  wire        phy_init_done_pin,
  input  wire        overtemp_alarm_pin,
  // Error counter values
  output wire [7:0]  single_error_counter_chan0,
  output wire [7:0]  single_error_counter_chan1
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Saturating eight-bit increment
  function [7:0] sat_inc;
    input [7:0] v;
    begin
      if (v == `MCSM_ERR_MAX)
        sat_inc = v;
      else
        sat_inc = v + 8'h01;
    end
  endfunction

  // Offset of a tracking register to its storage index
  function [3:0] track_index;
    input [16:0] ofs;
    begin
      if (ofs == `MCSM_OFS_WR_CH0)
        track_index = 4'd0;
      else if (ofs == `MCSM_OFS_WRAP_CH0)
        track_index = 4'd1;
      else if (ofs == `MCSM_OFS_RD_CH0)
        track_index = 4'd2;
      else if (ofs == `MCSM_OFS_RDAP_CH0)
        track_index = 4'd3;
      else if (ofs == `MCSM_OFS_REF_CH0)
        track_index = 4'd4;
      else if (ofs == `MCSM_OFS_ACT_CH0)
        track_index = 4'd5;
      else if (ofs == `MCSM_OFS_PRE_CH0)
        track_index = 4'd6;
      else if (ofs == `MCSM_OFS_WR_CH1)
        track_index = 4'd7;
      else if (ofs == `MCSM_OFS_WRAP_CH1)
        track_index = 4'd8;
      else if (ofs == `MCSM_OFS_RD_CH1)
        track_index = 4'd9;
      else if (ofs == `MCSM_OFS_RDAP_CH1)
        track_index = 4'd10;
      else if (ofs == `MCSM_OFS_REF_CH1)
        track_index = 4'd11;
      else if (ofs == `MCSM_OFS_ACT_CH1)
        track_index = 4'd12;
      else if (ofs == `MCSM_OFS_PRE_CH1)
        track_index = 4'd13;
      else
        track_index = `MCSM_TRACK_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg         clear_reg;
  reg  [7:0]  thresh_reg;
  reg  [7:0]  seen_reg    [0:1];
  reg  [7:0]  err_cnt_reg [0:1];
  reg  [1:0]  flag_reg;
  reg  [1:0]  phy_sync_reg;
  reg  [1:0]  temp_sync_reg;
  reg         phy_done_reg;
  reg         overtemp_reg;
  reg         repeat_reg;
  reg         single_reg;
  reg  [31:0] length_reg;
  reg  [31:0] tick_reg;
  reg  [1:0]  state_reg;
  reg         done_reg;
  reg  [31:0] work_reg    [0:13];
  reg  [31:0] track_reg   [0:13];
  reg  [31:0] rdata_next;
  reg         rerr_next;
  reg  [13:0] hit;
  integer     i, j, k, m;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------

  // Region check: the upper five bits pick this controller
  wire [16:0] ofs       = paddr[16:0];
  wire        region_ok = (paddr[21:17] == REGION_CODE);
  wire        access    = psel & penable & ~pready_reg;
  wire        wr_fire   = access & pwrite & region_ok;
  wire        rd_fire   = access & ~pwrite & region_ok;
  wire [3:0]  tidx      = track_index(ofs);

  // Per-register strobes
  wire wr_clear   = wr_fire & (ofs == `MCSM_OFS_ERR_CLEAR);
  wire wr_thresh  = wr_fire & (ofs == `MCSM_OFS_ERR_THRESH);
  wire wr_repeat  = wr_fire & (ofs == `MCSM_OFS_MON_REPEAT);
  wire wr_single  = wr_fire & (ofs == `MCSM_OFS_MON_SINGLE);
  wire wr_length  = wr_fire & (ofs == `MCSM_OFS_MON_LENGTH);
  wire rd_flag0   = rd_fire & (ofs == `MCSM_OFS_FLAG_CH0);
  wire rd_flag1   = rd_fire & (ofs == `MCSM_OFS_FLAG_CH1);
  wire rd_done    = rd_fire & (ofs == `MCSM_OFS_MON_DONE);

  // Read mux; unmapped offsets and foreign regions answer with an error
  always @*
  begin
    rdata_next = 32'h00000000;
    rerr_next  = 1'b0;
    if (!region_ok)
      rerr_next = 1'b1;
    else if (ofs == `MCSM_OFS_ERR_CLEAR)
      rdata_next = {31'h00000000, clear_reg};
    else if (ofs == `MCSM_OFS_ERR_THRESH)
      rdata_next = {24'h000000, thresh_reg};
    else if (ofs == `MCSM_OFS_FLAG_CH0)
      rdata_next = {31'h00000000, flag_reg[0]};
    else if (ofs == `MCSM_OFS_FLAG_CH1)
      rdata_next = {31'h00000000, flag_reg[1]};
    else if (ofs == `MCSM_OFS_PHY_DONE)
      rdata_next = {31'h00000000, phy_done_reg};
    else if (ofs == `MCSM_OFS_OVERTEMP)
      rdata_next = {31'h00000000, overtemp_reg};
    else if (ofs == `MCSM_OFS_MON_REPEAT)
      rdata_next = {31'h00000000, repeat_reg};
    else if (ofs == `MCSM_OFS_MON_SINGLE)
      rdata_next = {31'h00000000, single_reg};
    else if (ofs == `MCSM_OFS_MON_LENGTH)
      rdata_next = length_reg;
    else if (ofs == `MCSM_OFS_MON_DONE)
      rdata_next = {31'h00000000, done_reg};
    else if (tidx != `MCSM_TRACK_NONE)
      rdata_next = track_reg[tidx];
    else
      rerr_next = 1'b1;
  end

  // ----------------------------------------------------------------
  // APB response
  // ----------------------------------------------------------------

  // One wait state: the answer is registered, so pready never comes combinationally
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
    end
    else
    begin
      pready_reg  <= access;
      pslverr_reg <= access & rerr_next;
      if (access && !pwrite)
        prdata_reg <= rdata_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Software-written controls; tracking registers take no writes
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clear_reg  <= 1'b0;
      thresh_reg <= `MCSM_THRESH_RESET;
      repeat_reg <= 1'b0;
      length_reg <= `MCSM_LENGTH_RESET;
    end
    else
    begin
      if (wr_clear)
        clear_reg <= pwdata[0];
      if (wr_thresh)
        thresh_reg <= pwdata[7:0];
      if (wr_repeat)
        repeat_reg <= pwdata[0];
      if (wr_length)
        length_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // PHY status levels
  // ----------------------------------------------------------------

  // Two-stage synchronisers, then plain and sticky status bits
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phy_sync_reg  <= 2'b00;
      temp_sync_reg <= 2'b00;
      phy_done_reg  <= 1'b0;
      overtemp_reg  <= 1'b0;
    end
    else
    begin
      phy_sync_reg  <= {phy_sync_reg[0], phy_init_done_pin};
      temp_sync_reg <= {temp_sync_reg[0], overtemp_alarm_pin};
      phy_done_reg  <= phy_sync_reg[1];
      overtemp_reg  <= overtemp_reg | temp_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // Single-bit ECC error accounting
  // ----------------------------------------------------------------

  // Errors are first counted against the threshold; only those past it
  // reach the visible counter. A flag read loses to a same-cycle event.
  wire [1:0] err_in = {ecc_error_chan1, ecc_error_chan0};
  wire [1:0] rd_flag = {rd_flag1, rd_flag0};
  reg  [1:0] flag_set;

  always @*
  begin
    flag_set = 2'b00;
    for (j = 0; j < 2; j = j + 1)
      flag_set[j] = err_in[j] & ~clear_reg & (seen_reg[j] >= thresh_reg);
  end

  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_reg <= 2'b00;
      for (k = 0; k < 2; k = k + 1)
      begin
        seen_reg[k]    <= 8'h00;
        err_cnt_reg[k] <= 8'h00;
      end
    end
    else
    begin
      flag_reg <= (flag_reg & ~rd_flag) | flag_set;
      for (k = 0; k < 2; k = k + 1)
      begin
        if (clear_reg)
        begin
          seen_reg[k]    <= 8'h00;
          err_cnt_reg[k] <= 8'h00;
        end
        else if (err_in[k])
        begin
          seen_reg[k] <= sat_inc(seen_reg[k]);
          if (flag_set[k])
            err_cnt_reg[k] <= sat_inc(err_cnt_reg[k]);
        end
      end
    end
  end

  assign single_error_counter_chan0 = err_cnt_reg[0];
  assign single_error_counter_chan1 = err_cnt_reg[1];

  // ----------------------------------------------------------------
  // Activity monitor
  // ----------------------------------------------------------------

  // Which working counter each incoming command hits this cycle
  always @*
  begin
    hit = 14'h0000;
    for (m = 0; m < `MCSM_CMD_KINDS; m = m + 1)
    begin
      hit[m]     = cmd_valid_chan0 & (cmd_code_chan0 == m[2:0]);
      hit[m + 7] = cmd_valid_chan1 & (cmd_code_chan1 == m[2:0]);
    end
  end

  // Length zero behaves as one clock so the monitor never stalls
  wire [32:0] tick_plus = {1'b0, tick_reg} + 33'h000000001;
  wire        last_tick = (tick_plus >= {1'b0, length_reg});
  wire        go_repeat = wr_repeat & pwdata[0];
  wire        go_single = wr_single & pwdata[0] & ~repeat_reg;
  wire        finish    = (state_reg == ST_RUN) & last_tick;

  // Interval sequencer, working counters and tracking copies
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg  <= ST_IDLE;
      tick_reg   <= 32'h00000000;
      single_reg <= 1'b0;
      done_reg   <= 1'b0;
      for (i = 0; i < `MCSM_TRACK_NUM; i = i + 1)
      begin
        work_reg[i]  <= 32'h00000000;
        track_reg[i] <= 32'h00000000;
      end
    end
    else
    begin
      // A completion in the reading cycle keeps the bit set
      done_reg <= (done_reg & ~rd_done) | finish;
      if (wr_single)
        single_reg <= pwdata[0];
      case (state_reg)
        ST_IDLE:
        begin
          if (go_repeat || go_single)
          begin
            state_reg <= ST_RUN;
            tick_reg  <= 32'h00000000;
            for (i = 0; i < `MCSM_TRACK_NUM; i = i + 1)
              work_reg[i] <= 32'h00000000;
          end
        end
        ST_RUN:
        begin
          if (last_tick)
          begin
            // Commands of the last clock still land in this interval
            for (i = 0; i < `MCSM_TRACK_NUM; i = i + 1)
            begin
              track_reg[i] <= work_reg[i] + {31'h00000000, hit[i]};
              work_reg[i]  <= 32'h00000000;
            end
            tick_reg <= 32'h00000000;
            if (!repeat_reg)
            begin
              state_reg  <= ST_IDLE;
              single_reg <= 1'b0;
            end
            // Otherwise the next interval starts at once
          end
          else
          begin
            tick_reg <= tick_plus[31:0];
            for (i = 0; i < `MCSM_TRACK_NUM; i = i + 1)
              if (hit[i])
                work_reg[i] <= work_reg[i] + 32'h00000001;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Tracking registers change only on the copy above
  // Activate and precharge share the loop above

endmodule

`default_nettype wire

// *** sim/mcsm_status_monitor_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mcsm_defs.vh"
module mcsm_status_monitor_assertions
#(
  parameter [4:0] REGION_CODE = `MCSM_REGION_DEFAULT
)
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [21:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Error path
  input wire logic        ecc_error_chan0,
  input wire logic [7:0]  single_error_counter_chan0,
  input wire logic [7:0]  single_error_counter_chan1
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Access phase still waiting, then a one-cycle answer
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence

  a_one_wait_state: assert property (s_access |=> s_answer)
    else $error("answer not one cycle after access");
  a_ready_has_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without an access");
  a_foreign_refused: assert property (psel && penable && !pready &&
    paddr[21:17] != REGION_CODE |=> pslverr)
    else $error("foreign region not refused");
  a_refused_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_bit_regs_narrow: assert property (pready && !pwrite && !pslverr &&
    paddr[16:0] inside {`MCSM_OFS_FLAG_CH0, `MCSM_OFS_FLAG_CH1, `MCSM_OFS_PHY_DONE,
    `MCSM_OFS_OVERTEMP, `MCSM_OFS_MON_DONE} |-> prdata[31:1] == 31'h0)
    else $error("one-bit register shows upper bits");
  a_thresh_eight_bits: assert property (pready && !pwrite &&
    paddr[16:0] == `MCSM_OFS_ERR_THRESH |-> prdata[31:8] == 24'h0)
    else $error("threshold wider than eight bits");
  // Increment needs an error event; 9 bits so a clear from 255 is not a step
  a_count_needs_error: assert property ({1'b0, single_error_counter_chan0} ==
    {1'b0, $past(single_error_counter_chan0)} + 9'h001 |-> $past(ecc_error_chan0))
    else $error("counter stepped without error");
  a_sat_holds: assert property ($past(single_error_counter_chan1) == 8'hff |->
    single_error_counter_chan1 inside {8'hff, 8'h00})
    else $error("saturated counter moved");
  a_count_step_one: assert property ($changed(single_error_counter_chan1) |->
    single_error_counter_chan1 == $past(single_error_counter_chan1) + 8'h01 ||
    single_error_counter_chan1 == 8'h00)
    else $error("counter jumped");
endmodule
`default_nettype wire

// *** sim/mcsm_apb_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module mcsm_apb_host
(
  // Clock
  input wire logic         core_clk,
  // Answer from the device
  input wire logic  [31:0] prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  // Request to the device
  output var logic         psel = 1'b0,
  output var logic         penable = 1'b0,
  output var logic         pwrite = 1'b0,
  output var logic  [21:0] paddr = 22'h0,
  output var logic  [31:0] pwdata = 32'h0
);
  // One transfer; request held until ready is sampled high
  task automatic xfer(input logic w, input logic [21:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1 && ++n < 16);
    // A hang leaves unknowns so the caller's compare fails
    rd = (n < 16) ? prdata : 32'hx;
    er = (n < 16) ? pslverr : 1'bx;
    // Released lines show the inverse, never a stale match
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~w;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// *** sim/mcsm_status_monitor_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mcsm_defs.vh"
module mcsm_status_monitor_tb;
  localparam [4:0] RG = `MCSM_REGION_DEFAULT;
  typedef struct packed {logic w; logic [21:0] a; logic [31:0] d; logic [31:0] x; logic e;} mcsm_row_t;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        e0 = 1'b0, e1 = 1'b0, v0 = 1'b0, v1 = 1'b0, phy = 1'b0, ot = 1'b0;
  logic [2:0]  c0 = 3'h0, c1 = 3'h0;
  wire         psel, penable, pwrite, pready, pslverr;
  wire  [21:0] paddr;
  wire  [31:0] pwdata, prdata;
  wire  [7:0]  cnt0, cnt1;
  logic [31:0] rdv;
  logic        erv;
  int          err_count = 0, cmp_count = 0, cyc = 0, i, k;
  int          ex [14];
  mcsm_row_t   rows [14];

  mcsm_status_monitor #(.REGION_CODE(RG)) mcsm_status_monitor_inst (.core_clk(core_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ecc_error_chan0(e0), .ecc_error_chan1(e1), .cmd_valid_chan0(v0), .cmd_code_chan0(c0),
    .cmd_valid_chan1(v1), .cmd_code_chan1(c1), .phy_init_done_pin(phy),
    .overtemp_alarm_pin(ot), .single_error_counter_chan0(cnt0),
    .single_error_counter_chan1(cnt1));
  mcsm_apb_host mcsm_apb_host_inst (.core_clk(core_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));

  // Clock and cycle ceiling well above the planned run
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [16:0] o, input logic [31:0] d);
    mcsm_apb_host_inst.xfer(w, {RG, o}, d, rdv, erv);
  endtask
  // Two cycles per event so each pulse is one error
  task automatic pulse(input int n, input logic ch);
    repeat (n)
    begin
      @(posedge core_clk);
      e0 <= ~ch;
      e1 <= ch;
      @(posedge core_clk);
      e0 <= 1'b0;
      e1 <= 1'b0;
    end
    repeat (2) @(posedge core_clk);
  endtask
  // Host polls the done bit under a bound
  task automatic wait_done();
    rdv = 32'h0;
    for (int n = 0; n < 40 && rdv !== 32'h1; n++)
      acc(1'b0, `MCSM_OFS_MON_DONE, 32'h0);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    // A write answers with the data of the last read, held in the read register
    rows = '{'{0, {RG, `MCSM_OFS_ERR_THRESH}, 0, 0, 0}, '{0, {RG, `MCSM_OFS_ERR_CLEAR}, 0, 0, 0},
      '{0, {RG, `MCSM_OFS_FLAG_CH0}, 0, 0, 0}, '{0, {RG, `MCSM_OFS_FLAG_CH1}, 0, 0, 0},
      '{0, {RG, `MCSM_OFS_PHY_DONE}, 0, 0, 0}, '{0, {RG, `MCSM_OFS_OVERTEMP}, 0, 0, 0},
      '{1, {RG, `MCSM_OFS_ERR_THRESH}, 32'h1ff, 0, 0}, '{0, {RG, `MCSM_OFS_ERR_THRESH}, 0, 32'hff, 0},
      '{1, {RG, `MCSM_OFS_PHY_DONE}, 1, 32'hff, 0}, '{0, {RG, `MCSM_OFS_PHY_DONE}, 0, 0, 0},
      '{0, {RG, 17'h00004}, 0, 0, 1}, '{1, {5'h0c, `MCSM_OFS_ERR_THRESH}, 32'h55, 0, 1},
      '{0, {RG, `MCSM_OFS_ERR_THRESH}, 0, 32'hff, 0}, '{1, {RG, `MCSM_OFS_WR_CH0}, 7, 32'hff, 0}};
    do_reset();
    foreach (rows[r])
    begin
      mcsm_apb_host_inst.xfer(rows[r].w, rows[r].a, rows[r].d, rdv, erv);
      chk(rdv, rows[r].x, "row data");
      chk({31'h0, erv}, {31'h0, rows[r].e}, "row error");
    end
    $display("register rows done");
    acc(1'b1, `MCSM_OFS_MON_LENGTH, 32'd40);
    acc(1'b0, `MCSM_OFS_MON_LENGTH, 32'h0);
    chk(rdv, 32'd40, "interval length");
    acc(1'b1, `MCSM_OFS_MON_REPEAT, 32'h0);
    acc(1'b1, `MCSM_OFS_MON_SINGLE, 32'h1);
    for (i = 0; i < 28; i++)
    begin
      @(posedge core_clk);
      v0 <= 1'b1;
      v1 <= 1'b1;
      c0 <= i[2:0];
      c1 <= i[2:0] + 3'h3;
      if (i[2:0] != 3'h7) ex[i[2:0]]++;
      if (i[2:0] + 3'h3 != 3'h7) ex[7 + 3'(i[2:0] + 3'h3)]++;
    end
    @(posedge core_clk);
    v0 <= 1'b0;
    v1 <= 1'b0;
    wait_done();
    chk(rdv, 32'h1, "done set");
    acc(1'b0, `MCSM_OFS_MON_DONE, 32'h0);
    chk(rdv, 32'h0, "done self clear");
    for (k = 0; k < 14; k++)
    begin
      acc(1'b0, 17'(17'h13814 + 12 * (k % 7) + 4 * (k / 7)), 32'h0);
      chk(rdv, ex[k], "tracking");
    end
    repeat (100) @(posedge core_clk);
    acc(1'b0, `MCSM_OFS_MON_DONE, 32'h0);
    chk(rdv, 32'h0, "single runs once");
    acc(1'b0, `MCSM_OFS_WR_CH0, 32'h0);
    chk(rdv, ex[0], "tracking held");
    $display("single interval done");
    acc(1'b1, `MCSM_OFS_MON_REPEAT, 32'h1);
    wait_done();
    chk(rdv, 32'h1, "repeat first");
    acc(1'b0, `MCSM_OFS_WR_CH0, 32'h0);
    chk(rdv, 32'h0, "working cleared");
    wait_done();
    chk(rdv, 32'h1, "repeat again");
    acc(1'b1, `MCSM_OFS_MON_REPEAT, 32'h0);
    repeat (100) @(posedge core_clk);
    acc(1'b0, `MCSM_OFS_MON_DONE, 32'h0);
    repeat (100) @(posedge core_clk);
    acc(1'b0, `MCSM_OFS_MON_DONE, 32'h0);
    chk(rdv, 32'h0, "repeat stopped");
    $display("repeat interval done");
    acc(1'b1, `MCSM_OFS_ERR_THRESH, 32'h2);
    pulse(5, 1'b0);
    chk(cnt0, 32'h3, "count past threshold");
    acc(1'b0, `MCSM_OFS_FLAG_CH0, 32'h0);
    chk(rdv, 32'h1, "flag set");
    acc(1'b0, `MCSM_OFS_FLAG_CH0, 32'h0);
    chk(rdv, 32'h0, "flag read clear");
    acc(1'b0, `MCSM_OFS_FLAG_CH1, 32'h0);
    chk(rdv, 32'h0, "other flag");
    acc(1'b1, `MCSM_OFS_ERR_CLEAR, 32'h1);
    pulse(4, 1'b0);
    chk(cnt0, 32'h0, "held at zero");
    acc(1'b1, `MCSM_OFS_ERR_CLEAR, 32'h0);
    pulse(3, 1'b0);
    chk(cnt0, 32'h1, "counting resumed");
    acc(1'b1, `MCSM_OFS_ERR_THRESH, 32'h0);
    pulse(260, 1'b1);
    chk(cnt1, 32'hff, "saturation");
    $display("error counter done");
    @(posedge core_clk);
    phy <= 1'b1;
    ot <= 1'b1;
    repeat (4) @(posedge core_clk);
    ot <= 1'b0;
    repeat (6) @(posedge core_clk);
    acc(1'b0, `MCSM_OFS_PHY_DONE, 32'h0);
    chk(rdv, 32'h1, "phy done");
    acc(1'b0, `MCSM_OFS_OVERTEMP, 32'h0);
    chk(rdv, 32'h1, "alarm sticky");
    ot <= 1'b0;
    do_reset();
    acc(1'b0, `MCSM_OFS_ERR_THRESH, 32'h0);
    chk(rdv, 32'h0, "threshold after reset");
    chk(cnt1, 32'h0, "counter after reset");
    $display("status and reset done");
    final_report();
  end
endmodule
bind mcsm_status_monitor mcsm_status_monitor_assertions #(.REGION_CODE(REGION_CODE))
  mcsm_status_monitor_assertions_inst (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ecc_error_chan0(ecc_error_chan0),
  .single_error_counter_chan0(single_error_counter_chan0),
  .single_error_counter_chan1(single_error_counter_chan1));
`default_nettype wire
